// *** hdl/line_lock_defines.vh ***
// Purpose: constants for the subcarrier line lock divider
// Assumes: clock is the twice-subcarrier oscillator
// Notes:   counts are last divider values (ratio minus one), not times
`ifndef LINE_LOCK_DEFINES_VH
`define LINE_LOCK_DEFINES_VH
`define DIV_W            11
`define DIV_PAL_LAST     11'h46e
`define DIV_NTSC_LAST    11'h38d
`define DIV_RESET        11'h000
`define DIV_STEP         11'h001
`endif

// *** hdl/sync_filter.v ***
// Purpose: three-stage input synchroniser with agreement filter
// Assumes: input is asynchronous to clk_i
// Notes:   output changes once stages two and three agree
`timescale 1ns/1ps
module sync_filter
(
  input  wire clk_i,
  input  wire rst_n_i,
  input  wire din_i,
  output reg  dout_o
);
  reg s1_r;
  reg s2_r;
  reg s3_r;

  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      s1_r   <= 1'b0;
      s2_r   <= 1'b0;
      s3_r   <= 1'b0;
      dout_o <= 1'b0;
    end
    else
    begin
      s1_r <= din_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r)
        dout_o <= s3_r;
    end
  end
endmodule

// *** hdl/subcarrier_line_lock_divider.v ***
// Purpose: lock twice-subcarrier oscillator to display line rate
// Assumes: clk_i is the twice-subcarrier oscillator; syncs are async pins
// Notes:   phase error output feeds an external low-pass loop filter
// Function
// - divide oscillator by 1135 PAL, 910 NTSC
// - halve incoming line sync pulse train
// - phase compare both half-line signals
// - PAL: drop one clock per field
// - NTSC: no clock dropped, count all
// - cycle drop selectable for non-standard displays
// - flag mismatch when burst error reverses sign
// - on mismatch suppress one line sync per field
// - mismatch handling only in PAL mode
`timescale 1ns/1ps
`include "line_lock_defines.vh"
module subcarrier_line_lock_divider
(
  input  wire clk_i,
  input  wire rst_n_i,
  input  wire pal_mode_i,
  input  wire drop_override_i,
  input  wire drop_enable_i,
  input  wire composite_sync_input_i,
  input  wire field_sync_i,
  input  wire burst_error_sign_i,
  input  wire burst_error_strobe_i,
  output reg  osc_half_line_o,
  output reg  sync_half_line_o,
  output reg  phase_up_o,
  output reg  phase_down_o,
  output reg  mismatch_o,
  output reg  encoder_sync_o
);
  localparam ST_PASS     = 4'b0001;
  localparam ST_ARMED    = 4'b0010;
  localparam ST_SUPPRESS = 4'b0100;
  localparam ST_BLANK    = 4'b1000;

  wire               line_s;
  wire               field_s;
  reg                line_d_r;
  reg                field_d_r;
  reg  [`DIV_W-1:0]  div_r;
  reg  [`DIV_W-1:0]  div_last;
  reg                drop_en;
  reg                drop_pend_r;
  reg                last_sign_r;
  reg                sign_valid_r;
  reg  [3:0]         state_r;
  reg  [3:0]         state_nxt;
  wire               line_rise;
  wire               field_rise;
  wire               drop_now;
  wire               reversal;
  wire               blank_line;
  wire [`DIV_W:0]    div_inc;

  // =====================================================
  // input synchronisers
  sync_filter u_line_sync
  (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .din_i   (composite_sync_input_i),
    .dout_o  (line_s)
  );

  sync_filter u_field_sync
  (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .din_i   (field_sync_i),
    .dout_o  (field_s)
  );

  assign line_rise  = line_s & ~line_d_r;
  assign field_rise = field_s & ~field_d_r;

  // =====================================================
  // oscillator divider with per-field cycle drop
  always @*
  begin
    div_last = pal_mode_i ? `DIV_PAL_LAST : `DIV_NTSC_LAST;
    if (drop_override_i)
      drop_en = drop_enable_i;
    else
      drop_en = pal_mode_i;
  end

  assign drop_now = drop_pend_r & drop_en;
  assign div_inc  = {1'b0, div_r} + {1'b0, `DIV_STEP};

  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      div_r           <= `DIV_RESET;
      osc_half_line_o <= 1'b0;
      drop_pend_r     <= 1'b0;
      line_d_r        <= 1'b0;
      field_d_r       <= 1'b0;
    end
    else
    begin
      line_d_r  <= line_s;
      field_d_r <= field_s;
      // one drop per field; the pending mark is consumed by the drop
      if (field_rise)
        drop_pend_r <= 1'b1;
      else if (drop_now || !drop_en)
        drop_pend_r <= 1'b0;
      if (!drop_now)
      begin
        if (div_r >= div_last)
        begin
          div_r           <= `DIV_RESET;
          osc_half_line_o <= 1'b1;
        end
        else
        begin
          div_r <= div_inc[`DIV_W-1:0];
          if (div_r == {1'b0, div_last[`DIV_W-1:1]})
            osc_half_line_o <= 1'b0;
        end
      end
    end
  end

  // =====================================================
  // line sync halving and phase compare
  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sync_half_line_o <= 1'b0;
      phase_up_o       <= 1'b0;
      phase_down_o     <= 1'b0;
    end
    else
    begin
      if (line_rise && state_r != ST_SUPPRESS)
        sync_half_line_o <= ~sync_half_line_o;
      // xor-style detector, split by which half-line signal is high
      phase_up_o   <= sync_half_line_o & ~osc_half_line_o;
      phase_down_o <= osc_half_line_o & ~sync_half_line_o;
    end
  end

  // =====================================================
  // line alternation mismatch and sync suppression
  assign reversal = burst_error_strobe_i & sign_valid_r & (burst_error_sign_i != last_sign_r);

  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      last_sign_r  <= 1'b0;
      sign_valid_r <= 1'b0;
      mismatch_o   <= 1'b0;
    end
    else if (!pal_mode_i)
    begin
      sign_valid_r <= 1'b0;
      mismatch_o   <= 1'b0;
    end
    else
    begin
      if (burst_error_strobe_i)
      begin
        last_sign_r  <= burst_error_sign_i;
        sign_valid_r <= 1'b1;
        mismatch_o   <= reversal;
      end
    end
  end

  // =====================================================
  // suppression sequencer
  // suppress waits for the next line pulse, blank covers all of it
  assign blank_line = pal_mode_i & ((state_r == ST_BLANK) | ((state_r == ST_SUPPRESS) & line_rise));

  always @*
  begin
    state_nxt = state_r;
    case (state_r)
      ST_PASS:
        if (pal_mode_i && mismatch_o)
          state_nxt = ST_ARMED;
      ST_ARMED:
        if (!pal_mode_i)
          state_nxt = ST_PASS;
        else if (field_rise)
          state_nxt = ST_SUPPRESS;
      ST_SUPPRESS:
        if (!pal_mode_i)
          state_nxt = ST_PASS;
        else if (line_rise)
          state_nxt = ST_BLANK;
      ST_BLANK:
        if (!pal_mode_i || !line_s)
          state_nxt = ST_PASS;
      default:
        state_nxt = ST_PASS;
    endcase
  end

  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_r        <= ST_PASS;
      encoder_sync_o <= 1'b0;
    end
    else
    begin
      state_r        <= state_nxt;
      // in PAL after a mismatch, whole first line pulse after field sync is withheld
      encoder_sync_o <= line_s & ~blank_line;
    end
  end
endmodule

// *** test/disp_gen_model.sv ***
// Purpose: display generator model; Assumes: one clock; Notes: 4 lines a field
`timescale 1ns/1ps
module disp_gen_model #(parameter LINE = 568)
(
  input  wire clk_i,
  input  wire rev_i,
  output reg  composite_sync_input_o,
  output reg  fsync_o,
  output reg  stb_o,
  output reg  sign_o
);
  integer c = 0;
  integer n = 0;
  initial {composite_sync_input_o, fsync_o, stb_o, sign_o} = 4'h0;
  always @(posedge clk_i)
  begin
    c <= (c == LINE - 1) ? 0 : c + 1;
    if (c == LINE - 1)
      n <= n + 1;
    composite_sync_input_o <= c < 40;
    fsync_o <= c < 40 && n[1:0] == 2'h0;
    stb_o <= c == 100;
    sign_o <= rev_i & n[0];
  end
endmodule

// *** test/lla_chk_asserts.sv ***
// Purpose: port checker; Assumes: one clock; Notes: bound at foot
`timescale 1ns/1ps
module lla_chk
(
  input wire clk_i, rst_n_i, pal_mode_i, drop_override_i, drop_enable_i,
  input wire composite_sync_input_i, field_sync_i, burst_error_sign_i,
  input wire burst_error_strobe_i, osc_half_line_o, sync_half_line_o,
  input wire phase_up_o, phase_down_o, mismatch_o, encoder_sync_o
);
  reg  prev_r;
  reg  seen_r;
  wire rev_w = prev_r ^ burst_error_sign_i;
  always @(posedge clk_i or negedge rst_n_i)
    if (!rst_n_i)
      {prev_r, seen_r} <= 2'h0;
    else if (!pal_mode_i)
      seen_r <= 1'b0;
    else if (burst_error_strobe_i)
      {prev_r, seen_r} <= {burst_error_sign_i, 1'b1};
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  a_phase_excl: assert property (!(phase_up_o && phase_down_o))
    else $error("up and down");
  a_ntsc_no_flag: assert property (!pal_mode_i && !$past(pal_mode_i) |-> !mismatch_o)
    else $error("flag in ntsc");
  a_flag_hold: assert property ($changed(mismatch_o) && pal_mode_i && $past(pal_mode_i)
    |-> $past(burst_error_strobe_i)) else $error("flag moved");
  a_flag_cause: assert property (pal_mode_i && burst_error_strobe_i && seen_r
    |=> mismatch_o == $past(rev_w)) else $error("flag wrong");
  a_osc_hold: assert property ($changed(osc_half_line_o) |=> $stable(osc_half_line_o)[*8])
    else $error("osc glitch");
  a_half_hold: assert property ($changed(sync_half_line_o) |=> $stable(sync_half_line_o)[*8])
    else $error("half glitch");
  a_half_cause: assert property ($changed(sync_half_line_o) |-> $past(composite_sync_input_i, 3))
    else $error("half no sync");
  a_enc_cause: assert property ($rose(encoder_sync_o) |-> $past(composite_sync_input_i, 3))
    else $error("enc no sync");
  c_flag: cover property ($rose(mismatch_o));
  c_osc: cover property ($rose(osc_half_line_o));
  c_up: cover property ($rose(phase_up_o));
endmodule
bind subcarrier_line_lock_divider lla_chk chk (.*);

// *** test/subcarrier_line_lock_divider_bench.sv ***
// Purpose: bench; Assumes: 5 ns clock; Notes: model makes the syncs
`timescale 1ns/1ps
module subcarrier_line_lock_divider_bench;
  reg     clk_i = 0, rst_n_i = 0, pal = 1, ovr = 0, en = 0, rev = 0;
  wire    cs, fs, st, sg, osc, half, up, dn, mis, enc;
  integer fail_count = 0, tests_run = 0, k;
  disp_gen_model gen (.clk_i(clk_i), .rev_i(rev), .composite_sync_input_o(cs), .fsync_o(fs), .stb_o(st), .sign_o(sg));
  subcarrier_line_lock_divider uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .pal_mode_i(pal),
    .drop_override_i(ovr), .drop_enable_i(en), .composite_sync_input_i(cs), .field_sync_i(fs),
    .burst_error_sign_i(sg), .burst_error_strobe_i(st), .osc_half_line_o(osc),
    .sync_half_line_o(half), .phase_up_o(up), .phase_down_o(dn), .mismatch_o(mis), .encoder_sync_o(enc));
  initial forever #2.5 clk_i = ~clk_i;
  task chk(input [31:0] got, exp);
  begin
    tests_run = tests_run + 1;
    if (got !== exp)
    begin
      fail_count = fail_count + 1;
      $display("BAD %0t got %0d exp %0d", $time, got, exp);
    end
  end
  endtask
  task rise(input s, output integer n);
    reg q;
  begin
    n = 0;
    do
    begin
      q = s ? half : osc;
      @(posedge clk_i);
      #1;
      n = n + 1;
    end
    while (!(q === 1'b0 && (s ? half : osc) === 1'b1) && n < 3000);
  end
  endtask
  task t_div(input p, o, e, x);
    integer n, g, d;
  begin
    @(posedge clk_i);
    pal <= p;
    ovr <= o;
    en <= e;
    g = 0;
    d = 0;
    rise(0, n);
    rise(0, n);
    repeat (6)
    begin
      rise(0, n);
      g = g + (n == (p ? 1135 : 910));
      d = d + (n == (p ? 1136 : 911));
    end
    chk(g + d, 6);
    chk(d > 0, x);
  end
  endtask
  task t_half;
    integer n;
  begin
    rise(1, n);
    rise(1, n);
    chk(n, 1136);
  end
  endtask
  task t_mis(input p);
    integer cc, ce, sm, ph;
    reg a, b;
  begin
    @(posedge clk_i);
    pal <= p;
    rev <= 1;
    {cc, ce, sm, ph} = 0;
    repeat (600) @(posedge clk_i);
    for (k = 0; k < 9088; k = k + 1)
    begin
      a = cs;
      b = enc;
      @(posedge clk_i);
      #1;
      cc = cc + (cs & !a);
      ce = ce + (enc & !b);
      sm = sm | mis;
      ph = ph | up | dn;
    end
    chk(sm, p);
    chk(cc - ce > 1, p);
    chk(ph, 1);
  end
  endtask
  task end_sim;
  begin
    $display("checks %0d bad %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  end
  endtask
  initial
  begin
    repeat (10) @(posedge clk_i);
    chk({osc, half, up, dn, mis, enc}, 0);
    rst_n_i <= 1;
    t_div(1, 0, 0, 1);
    t_div(0, 0, 0, 0);
    t_div(1, 1, 0, 0);
    t_div(0, 1, 1, 1);
    t_half;
    t_mis(1);
    t_mis(0);
    end_sim;
  end
  initial
  begin
    #450000;
    fail_count = fail_count + 1;
    end_sim;
  end
endmodule
